/* File: src/wdg_pkg.sv */
// package of constants, register map and carrier types for the watchdog block
// assumes one 40 MHz clock mclk and an avalon-mm slave port with waitrequest
// Summary of operation
// - retriggerable one-shot; resets or interrupts at terminal count
// - counter advances only on dedicated oscillator ticks
// - only on and off; once on, stays on until reset
// - enabled by instruction or always-on option bit
// - always-on option runs watchdog without any instruction
// - clearing oscillator enable stops the rc oscillator
// - stopped oscillator means no counting, no time-out
// - 16-bit reloadable down-counter, two 8-bit reload registers
// - high byte bits 15..8, low byte 7..0
// - period in ms equals reload value over ten
// - time-out response selectable: short reset or exception
// - response bit 0 interrupts; 1 (default) short reset
package wdg_pkg;

	// ************************************************************
	// bus and data widths
	// ************************************************************
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int BYTE_W = 8;

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_RELOAD_HIGH = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_RELOAD_LOW = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_OSC_CTRL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_OPTION = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_MASK = 5'h18;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h1c;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BIT_OSC_ENABLE = 0;
	localparam int BIT_ALWAYS_ON = 0;
	localparam int BIT_RESP_SELECT = 1;
	localparam int BIT_CMD_INSTR = 0;
	localparam int BIT_ST_TIMEOUT = 0;
	localparam int BIT_ST_RESET = 1;
	localparam int BIT_RUNNING = 8;
	localparam int EVT_W = 2;

	// ************************************************************
	// values after reset
	// ************************************************************
	localparam logic [BYTE_W-1:0] RST_RELOAD_HIGH = 8'h04;
	localparam logic [BYTE_W-1:0] RST_RELOAD_LOW = 8'h00;
	localparam logic RST_OSC_ENABLE = 1'b1;
	localparam logic RST_ALWAYS_ON = 1'b0;
	localparam logic RST_RESP_SELECT = 1'b1;
	localparam logic [EVT_W-1:0] RST_MASK = 2'h0;
	localparam logic [CNT_W-1:0] RST_COUNT = 16'hffff;

	// ************************************************************
	// timing: system clock and nominal rc oscillator
	// ************************************************************
	localparam int MCLK_HZ = 40000000;
	localparam int RC_OSC_HZ = 10000;
	localparam int OSC_DIV_CYCLES = MCLK_HZ / RC_OSC_HZ;
	localparam int RESET_PULSE_CYCLES = 8;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed
	{
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [DATA_W-1:0] writedata;
	} wdg_avs_req_s;

	typedef enum logic [1:0]
	{
		WDG_OFF = 2'b01,
		WDG_ON = 2'b10
	} wdg_state_e;

endpackage : wdg_pkg

/* File: src/wdg_rc_osc.sv */
// dedicated tick source standing in for the on-chip rc oscillator
// assumes mclk free running; tick is a one-cycle pulse per oscillator period
`timescale 1ns/100ps
module wdg_rc_osc
#(
	parameter int DIV = wdg_pkg::OSC_DIV_CYCLES
)
(
	input wire logic mclk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic osc_enable, // oscillator runs while high
	output logic osc_tick // one pulse per oscillator period
);
	import wdg_pkg::*;

	logic [12:0] phase_reg;

	// ************************************************************
	// divider: stops and restarts from zero when disabled
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_reg <= 13'h0000;
			osc_tick <= 1'b0;
		end
		else if (!osc_enable)
		begin
			phase_reg <= 13'h0000;
			osc_tick <= 1'b0;
		end
		else if (phase_reg == 13'(DIV - 1))
		begin
			phase_reg <= 13'h0000;
			osc_tick <= 1'b1;
		end
		else
		begin
			phase_reg <= phase_reg + 13'h0001;
			osc_tick <= 1'b0;
		end
	end

endmodule : wdg_rc_osc

/* File: src/wdg_timer.sv */
// watchdog top: avalon-mm register slave, down-counter and time-out response
// assumes a single 40 MHz clock; software is the only party on the far side
`timescale 1ns/100ps
module wdg_timer
#(
	parameter int OSC_DIV = wdg_pkg::OSC_DIV_CYCLES,
	parameter int RESET_LEN = wdg_pkg::RESET_PULSE_CYCLES
)
(
	input wire logic mclk, // system clock, 40 MHz
	input wire logic arst_n, // async reset, active low
	input wire wdg_pkg::wdg_avs_req_s avs_req, // address, read, write, writedata
	output logic [wdg_pkg::DATA_W-1:0] avs_readdata, // read data
	output logic avs_waitrequest, // low for the accepting cycle
	output logic irq, // level interrupt, unmasked status set
	output logic short_reset, // short reset request to the device
	output logic running // watchdog is on
);
	import wdg_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	logic [BYTE_W-1:0] reload_high_byte_reg;
	logic [BYTE_W-1:0] reload_low_byte_reg;
	logic wdog_osc_enable_reg;
	logic always_on_option_reg;
	logic timeout_response_select_reg;
	logic [EVT_W-1:0] status_reg;
	logic [EVT_W-1:0] status_next;
	logic [EVT_W-1:0] mask_reg;
	logic [CNT_W-1:0] watchdog_counter_reg;
	logic [CNT_W-1:0] watchdog_counter_next;
	wdg_state_e state_reg;
	wdg_state_e state_next;
	logic [7:0] reset_len_reg;
	logic osc_tick;
	logic osc_tick_raw;
	logic accept;
	logic wr_hit;
	logic instr_pulse;
	logic timeout_evt;
	logic [EVT_W-1:0] evt_set;
	logic [EVT_W-1:0] evt_clr;
	logic [DATA_W-1:0] read_mux;

	// ************************************************************
	// helper functions
	// ************************************************************

	// true when a byte address matches a register offset
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// reload value built from the two byte registers
	function automatic logic [CNT_W-1:0] reload_value(input logic [BYTE_W-1:0] hi,
		input logic [BYTE_W-1:0] lo);
		reload_value = {hi, lo};
	endfunction : reload_value

	// ************************************************************
	// avalon handshake
	// ************************************************************

	// a request is accepted in the cycle waitrequest is low
	assign accept = (avs_req.read || avs_req.write) && !avs_waitrequest;
	assign wr_hit = accept && avs_req.write;

	// waitrequest drops for one cycle after a request is seen
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			avs_waitrequest <= 1'b1;
		else if ((avs_req.read || avs_req.write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	// ************************************************************
	// read data
	// ************************************************************

	// read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		read_mux = '0;
		unique case (1'b1)
			hit(avs_req.address, OFS_RELOAD_HIGH):
				read_mux[BYTE_W-1:0] = reload_high_byte_reg;
			hit(avs_req.address, OFS_RELOAD_LOW):
				read_mux[BYTE_W-1:0] = reload_low_byte_reg;
			hit(avs_req.address, OFS_OSC_CTRL):
				read_mux[BIT_OSC_ENABLE] = wdog_osc_enable_reg;
			hit(avs_req.address, OFS_OPTION):
			begin
				read_mux[BIT_ALWAYS_ON] = always_on_option_reg;
				read_mux[BIT_RESP_SELECT] = timeout_response_select_reg;
			end
			hit(avs_req.address, OFS_STATUS):
			begin
				read_mux[EVT_W-1:0] = status_reg;
				read_mux[BIT_RUNNING] = (state_reg == WDG_ON);
			end
			hit(avs_req.address, OFS_MASK):
				read_mux[EVT_W-1:0] = mask_reg;
			hit(avs_req.address, OFS_COUNT):
				read_mux[CNT_W-1:0] = watchdog_counter_reg;
			default:
				read_mux = '0;
		endcase
	end

	// read data captured while waitrequest is still high
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			avs_readdata <= 32'h0000_0000;
		else if (avs_req.read && avs_waitrequest)
			avs_readdata <= read_mux;
	end

	// ************************************************************
	// writable registers
	// ************************************************************

	// reload bytes
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reload_high_byte_reg <= RST_RELOAD_HIGH;
			reload_low_byte_reg <= RST_RELOAD_LOW;
		end
		else if (wr_hit && hit(avs_req.address, OFS_RELOAD_HIGH))
			reload_high_byte_reg <= avs_req.writedata[BYTE_W-1:0];
		else if (wr_hit && hit(avs_req.address, OFS_RELOAD_LOW))
			reload_low_byte_reg <= avs_req.writedata[BYTE_W-1:0];
	end

	// oscillator control
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			wdog_osc_enable_reg <= RST_OSC_ENABLE;
		else if (wr_hit && hit(avs_req.address, OFS_OSC_CTRL))
			wdog_osc_enable_reg <= avs_req.writedata[BIT_OSC_ENABLE];
	end

	// option bits: always-on and time-out response
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			always_on_option_reg <= RST_ALWAYS_ON;
			timeout_response_select_reg <= RST_RESP_SELECT;
		end
		else if (wr_hit && hit(avs_req.address, OFS_OPTION))
		begin
			always_on_option_reg <= avs_req.writedata[BIT_ALWAYS_ON];
			timeout_response_select_reg <= avs_req.writedata[BIT_RESP_SELECT];
		end
	end

	// interrupt mask
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			mask_reg <= RST_MASK;
		else if (wr_hit && hit(avs_req.address, OFS_MASK))
			mask_reg <= avs_req.writedata[EVT_W-1:0];
	end

	// watchdog instruction: write of a one to the command bit
	assign instr_pulse = wr_hit && hit(avs_req.address, OFS_COMMAND)
		&& avs_req.writedata[BIT_CMD_INSTR];

	// ************************************************************
	// dedicated oscillator
	// ************************************************************

	// tick source, halted when the enable bit is clear
	wdg_rc_osc
	#(
		.DIV(OSC_DIV)
	)
	u_rc_osc
	(
		.mclk(mclk),
		.arst_n(arst_n),
		.osc_enable(wdog_osc_enable_reg),
		.osc_tick(osc_tick_raw)
	);

	// a tick already in flight when the enable drops is discarded
	assign osc_tick = osc_tick_raw && wdog_osc_enable_reg;

	// ************************************************************
	// on/off state
	// ************************************************************

	// off until instruction or always-on; never returns to off
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			WDG_OFF:
				if (instr_pulse || always_on_option_reg)
					state_next = WDG_ON;
			WDG_ON:
				state_next = WDG_ON;
			default:
				state_next = WDG_OFF;
		endcase
	end

	// state register
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= WDG_OFF;
		else
			state_reg <= state_next;
	end

	// ************************************************************
	// down-counter
	// ************************************************************

	// time-out when an oscillator tick finds the count at one or below
	assign timeout_evt = (state_reg == WDG_ON) && osc_tick
		&& (watchdog_counter_reg <= 16'h0001) && !instr_pulse;

	// next count: reload on enable, refresh or time-out, else count down
	always_comb
	begin
		watchdog_counter_next = watchdog_counter_reg;
		if (state_reg == WDG_OFF)
		begin
			if (state_next == WDG_ON)
				watchdog_counter_next = reload_value(reload_high_byte_reg,
					reload_low_byte_reg);
		end
		else if (instr_pulse)
			watchdog_counter_next = reload_value(reload_high_byte_reg,
				reload_low_byte_reg);
		else if (timeout_evt)
			watchdog_counter_next = reload_value(reload_high_byte_reg,
				reload_low_byte_reg);
		else if (osc_tick)
			watchdog_counter_next = watchdog_counter_reg - 16'h0001;
	end

	// counter register
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			watchdog_counter_reg <= RST_COUNT;
		else
			watchdog_counter_reg <= watchdog_counter_next;
	end

	// ************************************************************
	// time-out response
	// ************************************************************

	// short reset pulse of fixed length when response bit is one
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			reset_len_reg <= 8'h00;
		else if (timeout_evt && timeout_response_select_reg)
			reset_len_reg <= 8'(RESET_LEN);
		else if (reset_len_reg != 8'h00)
			reset_len_reg <= reset_len_reg - 8'h01;
	end

	// reset output from a flip-flop
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			short_reset <= 1'b0;
		else
			short_reset <= (timeout_evt && timeout_response_select_reg)
				|| (reset_len_reg > 8'h01);
	end

	// ************************************************************
	// status, mask and interrupt
	// ************************************************************

	// events: interrupt-kind and reset-kind time-outs
	assign evt_set[BIT_ST_TIMEOUT] = timeout_evt && !timeout_response_select_reg;
	assign evt_set[BIT_ST_RESET] = timeout_evt && timeout_response_select_reg;

	// write one to clear; a set in the same cycle wins
	assign evt_clr = (wr_hit && hit(avs_req.address, OFS_STATUS))
		? avs_req.writedata[EVT_W-1:0] : '0;
	assign status_next = (status_reg & ~evt_clr) | evt_set;

	// sticky status
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			status_reg <= '0;
		else
			status_reg <= status_next;
	end

	// level interrupt while any unmasked status bit is set
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(status_next & mask_reg);
	end

	// running indication
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			running <= 1'b0;
		else
			running <= (state_next == WDG_ON);
	end

endmodule : wdg_timer

/* File: sim/wdg_timer_sva.sv */
// checker: bus handshake, sticky run state and short reset pulse of the watchdog
// assumes it is bound to wdg_timer and sees only its ports
`timescale 1ns/100ps
module wdg_timer_sva
#(
	parameter int OSC_DIV = wdg_pkg::OSC_DIV_CYCLES,
	parameter int RESET_LEN = wdg_pkg::RESET_PULSE_CYCLES
)
(
	input wire logic mclk, // clock
	input wire logic arst_n, // reset, active low
	input wire wdg_pkg::wdg_avs_req_s avs_req, // bus request
	input wire logic [wdg_pkg::DATA_W-1:0] avs_readdata, // read data
	input wire logic avs_waitrequest, // bus wait
	input wire logic irq, // interrupt level
	input wire logic short_reset, // reset pulse
	input wire logic running // watchdog on
);
	import wdg_pkg::*;
	logic [7:0] sr_len_reg;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ************************************************************
	// helper: length of the running short reset pulse
	// ************************************************************
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			sr_len_reg <= 8'h00;
		else if (short_reset)
			sr_len_reg <= sr_len_reg + 8'h01;
		else
			sr_len_reg <= 8'h00;
	end
	// ************************************************************
	// assertions
	// ************************************************************
	wait_one_a: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("no accept one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	wait_cause_a: assert property (!avs_waitrequest
		|-> $past(avs_req.read) || $past(avs_req.write)) else $error("accept without request");
	rdata_hold_a: assert property (!avs_req.read |=> $stable(avs_readdata))
		else $error("read data changed without read");
	run_sticky_a: assert property (running |=> running)
		else $error("watchdog turned off");
	sr_length_a: assert property ($fell(short_reset) |-> sr_len_reg == RESET_LEN)
		else $error("short reset length wrong");
	sr_cause_a: assert property ($rose(short_reset) |-> running)
		else $error("short reset while watchdog off");
	irq_cause_a: assert property (irq |-> running)
		else $error("interrupt while watchdog off");
	// main scenarios
	cover property (!avs_waitrequest && avs_req.read);
	cover property ($rose(irq));
	cover property ($fell(short_reset));
endmodule : wdg_timer_sva

bind wdg_timer wdg_timer_sva #(.OSC_DIV(OSC_DIV), .RESET_LEN(RESET_LEN)) u_sva (.mclk(mclk),
	.arst_n(arst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .short_reset(short_reset), .running(running));

/* File: sim/wdg_timer_tb.sv */
// testbench: register access, time-out responses, refresh and always-on start
// assumes wdg_timer with a short oscillator divider and short reset pulse
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module wdg_timer_tb;
	import wdg_pkg::*;
	localparam int RLEN = 4;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	wdg_avs_req_s req = '0;
	logic [DATA_W-1:0] rdata;
	logic waitreq, irq, sreset, running;
	logic [DATA_W-1:0] q;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	// ************************************************************
	// clock, design and hang guard
	// ************************************************************
	always #12.5 mclk = ~mclk;
	wdg_timer #(.OSC_DIV(4), .RESET_LEN(RLEN)) dut (.mclk(mclk), .arst_n(arst_n),
		.avs_req(req), .avs_readdata(rdata), .avs_waitrequest(waitreq), .irq(irq),
		.short_reset(sreset), .running(running));
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			num_errors++;
			stop_test();
		end
	end
	// ************************************************************
	// bus tasks and verdict
	// ************************************************************
	task stop_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	// one avalon access held until waitrequest is seen low
	task acc(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		req.address <= a;
		req.write <= w;
		req.read <= ~w;
		req.writedata <= d;
		// waitrequest and read data seen as they stood at each rising edge
		do
			@(posedge mclk);
		while (waitreq !== 1'b0);
		q = rdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : acc
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		acc(a, 1'b1, d);
	endtask : wr
	task rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string s);
		acc(a, 1'b0, '0);
		`CHK(s, e, q)
	endtask : rc
	// ************************************************************
	// tests
	// ************************************************************
	initial
	begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		rc(OFS_RELOAD_HIGH, 32'h4, "rel_hi");
		rc(OFS_RELOAD_LOW, 32'h0, "rel_lo");
		rc(OFS_OSC_CTRL, 32'h1, "osc");
		rc(OFS_OPTION, 32'h2, "option");
		rc(OFS_STATUS, 32'h0, "status");
		rc(OFS_MASK, 32'h0, "mask");
		rc(OFS_COUNT, 32'hffff, "count");
		rc(5'h01, 32'h0, "unmapped");
		`CHK("running", 1'b0, running)
		$display("test reset values done");
		wr(OFS_OSC_CTRL, 32'h0);
		wr(OFS_RELOAD_HIGH, 32'h1ab);
		wr(OFS_RELOAD_LOW, 32'h2);
		wr(OFS_COUNT, 32'h0);
		rc(OFS_RELOAD_HIGH, 32'hab, "rel_hi");
		rc(OFS_COUNT, 32'hffff, "count_ro");
		wr(OFS_COMMAND, 32'h1);
		rc(OFS_COUNT, 32'hab02, "count_load");
		`CHK("running", 1'b1, running)
		repeat (40) @(posedge mclk);
		rc(OFS_COUNT, 32'hab02, "count_stop");
		rc(OFS_STATUS, 32'h100, "status_stop");
		wr(OFS_RELOAD_HIGH, 32'h0);
		wr(OFS_RELOAD_LOW, 32'h3);
		wr(OFS_COMMAND, 32'h1);
		rc(OFS_COUNT, 32'h3, "count_reload");
		rc(OFS_COMMAND, 32'h0, "command");
		$display("test reload and stop done");
		wr(OFS_OPTION, 32'h0);
		wr(OFS_MASK, 32'h1);
		wr(OFS_OSC_CTRL, 32'h1);
		n = 0;
		while (irq !== 1'b1 && n < 60)
		begin
			@(negedge mclk);
			n++;
		end
		`CHK("irq", 1'b1, irq)
		`CHK("period", 1'b1, n >= 10 && n <= 16)
		`CHK("sreset", 1'b0, sreset)
		wr(OFS_OSC_CTRL, 32'h0);
		rc(OFS_STATUS, 32'h101, "status_irq");
		wr(OFS_STATUS, 32'h1);
		rc(OFS_STATUS, 32'h100, "status_clr");
		`CHK("irq_clr", 1'b0, irq)
		wr(OFS_MASK, 32'h0);
		wr(OFS_OSC_CTRL, 32'h1);
		repeat (30) @(posedge mclk);
		wr(OFS_OSC_CTRL, 32'h0);
		`CHK("irq_masked", 1'b0, irq)
		rc(OFS_STATUS, 32'h101, "status_masked");
		wr(OFS_MASK, 32'h1);
		repeat (2) @(negedge mclk);
		`CHK("irq_unmask", 1'b1, irq)
		wr(OFS_STATUS, 32'h1);
		repeat (2) @(negedge mclk);
		`CHK("irq_off", 1'b0, irq)
		$display("test interrupt response done");
		wr(OFS_OSC_CTRL, 32'h1);
		repeat (12) wr(OFS_COMMAND, 32'h1);
		wr(OFS_OSC_CTRL, 32'h0);
		`CHK("irq_refresh", 1'b0, irq)
		rc(OFS_STATUS, 32'h100, "status_refresh");
		$display("test refresh done");
		wr(OFS_OPTION, 32'h2);
		wr(OFS_OSC_CTRL, 32'h1);
		n = 0;
		while (sreset !== 1'b1 && n < 60)
		begin
			@(negedge mclk);
			n++;
		end
		`CHK("sreset", 1'b1, sreset)
		n = 0;
		while (sreset === 1'b1 && n < 20)
		begin
			n++;
			@(negedge mclk);
		end
		`CHK("sreset_len", RLEN, n)
		wr(OFS_OSC_CTRL, 32'h0);
		`CHK("irq_sreset", 1'b0, irq)
		rc(OFS_STATUS, 32'h102, "status_sreset");
		$display("test short reset done");
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		`CHK("running_rst", 1'b0, running)
		wr(OFS_OPTION, 32'h3);
		repeat (3) @(negedge mclk);
		`CHK("running_ao", 1'b1, running)
		$display("test always on done");
		stop_test();
	end
endmodule : wdg_timer_tb
